// ==== rtl/tpwm_top.sv ====
// Timer PWM waveform block with AXI4-Lite register access
`timescale 1ns/10ps
// Operation
// - Modes 3 and 7 count up from zero to the ceiling, then restart.
// - Fast ceiling is 0xFF in mode 3, compare_a in mode 7.
// - Fast output mode two clears on match, sets at zero; three inverts.
// - Fast counter increments to the ceiling, then clears next tick.
// - Fast mode raises overflow_flag whenever the counter hits the ceiling.
// - Fast mode, bit2 set, channel A mode one toggles on match.
// - Fast bottom update happens in the tick the counter wraps.
// - Fast compare zero yields a one-tick pulse each ceiling-plus-one ticks.
// - Fast compare at ceiling yields constant level set by polarity.
// - Compare double buffering stays active in fast mode, toggle included.
// - Modes 1 and 5 run dual slope; ceiling 0xFF or compare_a.
// - Dual slope reverses at ceiling, holding it for exactly one tick.
// - Non-inverting dual slope clears on up match, sets on down match.
// - Dual slope raises overflow_flag whenever the counter reaches zero while counting down.
// - Dual slope modes two and three set polarity; channel A may toggle in mode 5 only (bit2 set).
// - Dual slope compare zero holds low, ceiling holds high, non-inverted.
// - Dual slope compare at ceiling gives the down-match level.
// - Leaving ceiling compare forces up-match level at period start.
// - A missed up match also forces the up-match level.
// - Output mode zero does nothing and leaves the pin to the port.
module tpwm_top
    import tpwm_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_tick,
    input  wire logic [TP_ADDR_W-1:0] i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [TP_ADDR_W-1:0] i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic                      o_output_a,
    output logic                      o_output_b,
    output logic                      o_ovr_a,
    output logic                      o_ovr_b,
    output logic                      o_overflow_flag,
    output logic [TP_W-1:0]           o_count_value
);
    logic            rst_s1_q;
    logic            rst_n_q;
    logic [7:0]      ctrl_q;
    logic [TP_W-1:0] cmpa_buf_q;
    logic [TP_W-1:0] cmpb_buf_q;
    logic [TP_W-1:0] cmpa_q;
    logic [TP_W-1:0] cmpb_q;
    logic [TP_W-1:0] cnt_q;
    logic [TP_W-1:0] cnt_d;
    tpwm_dir_t       dir_q;
    tpwm_dir_t       dir_d;
    logic            ovf_q;
    logic            blk_q;
    logic            wr;
    logic            rd;
    logic [31:0]     rd_word;

    // Reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    tpwm_axil u_axil (
        .i_mclk    (i_mclk),
        .i_rst_n   (rst_n_q),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_wr      (wr),
        .o_rd      (rd),
        .i_rd_word (rd_word)
    );

    // Register write decode
    wire [TP_W-1:0] wbyte  = i_wdata[TP_W-1:0];
    wire wr_ctrl  = wr && (i_awaddr == TP_OFF_CTRL);
    wire wr_cmpa  = wr && (i_awaddr == TP_OFF_CMPA);
    wire wr_cmpb  = wr && (i_awaddr == TP_OFF_CMPB);
    wire wr_cnt   = wr && (i_awaddr == TP_OFF_COUNT);
    wire ovf_clr  = wr && (i_awaddr == TP_OFF_STAT) && wbyte[TP_STAT_OVF];

    // Mode decode
    wire [2:0] wgm  = {ctrl_q[TP_CTRL_WGM2], ctrl_q[1:0]};
    wire fast       = (wgm == TP_FAST_8) || (wgm == TP_FAST_A);
    wire pc         = (wgm == TP_PC_8) || (wgm == TP_PC_A);
    wire top_from_a = (wgm == TP_FAST_A) || (wgm == TP_PC_A);
    wire [TP_W-1:0] top = top_from_a ? cmpa_q : TP_MAX;
    wire at_top     = (cnt_q == top);
    wire at_bot     = (cnt_q == TP_BOTTOM);
    wire going_up   = (dir_q == TPWM_UP);
    wire [1:0] com_a = ctrl_q[TP_CTRL_COMA +: 2];
    wire [1:0] com_b = ctrl_q[TP_CTRL_COMB +: 2];

    // Buffered compares reach the comparators on the ceiling tick in PWM modes (counting up in dual slope), every cycle otherwise
    wire ld_fast = i_tick && fast && at_top;
    wire ld_pc   = i_tick && pc && at_top && going_up;
    wire ld      = !(fast || pc) || ld_fast || ld_pc;

    wire [TP_W-1:0] cnt_inc = cnt_q + 8'h01;
    wire [TP_W-1:0] cnt_dec = cnt_q - 8'h01;
    wire pc_turn_dn = going_up && at_top && !at_bot;
    wire pc_turn_up = !going_up && at_bot;

    always_comb
    begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (!(fast || pc))
            dir_d = TPWM_UP;
        if (wr_cnt)
            cnt_d = wbyte;
        else if (i_tick && fast)
            cnt_d = at_top ? TP_BOTTOM : cnt_inc;
        else if (i_tick && pc)
        begin
            case (dir_q)
                TPWM_UP:
                begin
                    if (at_top && at_bot)
                        cnt_d = TP_BOTTOM;
                    else if (pc_turn_dn)
                    begin
                        cnt_d = cnt_dec;
                        dir_d = TPWM_DOWN;
                    end
                    else
                        cnt_d = cnt_inc;
                end
                TPWM_DOWN:
                begin
                    if (pc_turn_up)
                    begin
                        cnt_d = cnt_inc;
                        dir_d = TPWM_UP;
                    end
                    else
                        cnt_d = cnt_dec;
                end
                default:
                begin
                    cnt_d = TP_BOTTOM;
                    dir_d = TPWM_UP;
                end
            endcase
        end
        else if (i_tick)
            cnt_d = cnt_inc;
    end

    // Overflow events; a set in the clearing cycle wins
    wire ovf_fast = i_tick && fast && at_top;
    wire ovf_pc   = i_tick && pc && at_bot && !going_up;
    wire ovf_norm = i_tick && !(fast || pc) && (cnt_q == TP_MAX);
    wire ovf_set  = ovf_fast || ovf_pc || ovf_norm;

    always_ff @(posedge i_mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctrl_q     <= TP_CTRL_RST;
            cmpa_buf_q <= TP_CMP_RST;
            cmpb_buf_q <= TP_CMP_RST;
            cmpa_q     <= TP_CMP_RST;
            cmpb_q     <= TP_CMP_RST;
            cnt_q      <= TP_BOTTOM;
            dir_q      <= TPWM_UP;
            ovf_q      <= 1'b0;
            blk_q      <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wbyte & TP_CTRL_MASK;
            if (wr_cmpa)
                cmpa_buf_q <= wbyte;
            if (wr_cmpb)
                cmpb_buf_q <= wbyte;
            if (ld)
            begin
                cmpa_q <= cmpa_buf_q;
                cmpb_q <= cmpb_buf_q;
            end
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            ovf_q <= ovf_set || (ovf_q && !ovf_clr);
            // A count write masks matches for the following tick
            blk_q <= wr_cnt || (blk_q && !i_tick);
        end
    end

    // Read mux; reserved bits read zero
    wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
    wire [31:0] rd_cmpa = {24'h000000, cmpa_buf_q};
    wire [31:0] rd_cmpb = {24'h000000, cmpb_buf_q};
    wire [31:0] rd_cnt  = {24'h000000, cnt_q};
    wire [31:0] rd_stat = {30'h00000000, going_up, ovf_q};
    assign rd_word = (i_araddr == TP_OFF_CTRL)  ? rd_ctrl :
                     (i_araddr == TP_OFF_CMPA)  ? rd_cmpa :
                     (i_araddr == TP_OFF_CMPB)  ? rd_cmpb :
                     (i_araddr == TP_OFF_COUNT) ? rd_cnt  :
                     (i_araddr == TP_OFF_STAT)  ? rd_stat : 32'h00000000;

    wire blk = blk_q || wr_cnt;

    // Channel A may toggle, channel B may not
    tpwm_chan #(.TOG_OK(1'b1)) u_chan_a (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n_q),
        .i_tick  (i_tick),
        .i_fast  (fast),
        .i_pc    (pc),
        .i_blk   (blk),
        .i_up    (going_up),
        .i_cnt   (cnt_q),
        .i_top   (top),
        .i_ocr   (cmpa_q),
        .i_mode  (com_a),
        .i_bit2  (ctrl_q[TP_CTRL_WGM2]),
        .o_out   (o_output_a),
        .o_ovr   (o_ovr_a)
    );

    tpwm_chan #(.TOG_OK(1'b0)) u_chan_b (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n_q),
        .i_tick  (i_tick),
        .i_fast  (fast),
        .i_pc    (pc),
        .i_blk   (blk),
        .i_up    (going_up),
        .i_cnt   (cnt_q),
        .i_top   (top),
        .i_ocr   (cmpb_q),
        .i_mode  (com_b),
        .i_bit2  (ctrl_q[TP_CTRL_WGM2]),
        .o_out   (o_output_b),
        .o_ovr   (o_ovr_b)
    );

    assign o_overflow_flag = ovf_q;
    assign o_count_value   = cnt_q;

    AST_FAST_WRAP: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && fast && at_top && !wr_cnt) |=> (cnt_q == TP_BOTTOM))
        else $error("fast counter did not wrap at ceiling");
    AST_FAST_INC: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && fast && !at_top && !wr_cnt)
        |=> (cnt_q == $past(cnt_inc)))
        else $error("fast counter did not increment");
    AST_FAST_MAX: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && wgm == TP_FAST_8 && cnt_q == TP_MAX && !wr_cnt)
        |=> (cnt_q == TP_BOTTOM))
        else $error("mode 3 ceiling is not 0xff");
    AST_OVF_FAST: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && fast && at_top) |=> ovf_q)
        else $error("overflow not raised at fast ceiling");
    AST_OVF_PC: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && pc && at_bot && !going_up) |=> ovf_q)
        else $error("overflow not raised at dual slope bottom");
    AST_PC_HOLD: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (i_tick && pc && pc_turn_dn && !wr_cnt)
        |=> (dir_q == TPWM_DOWN) && (cnt_q == $past(cnt_dec)))
        else $error("dual slope did not turn at ceiling");
    AST_PC_LOAD: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        ld_pc |=> (cmpa_q == $past(cmpa_buf_q)))
        else $error("compare not loaded at dual slope ceiling");
    AST_BUF_HOLD: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (fast && !ld_fast) |=> (cmpb_q == $past(cmpb_q)))
        else $error("compare changed outside wrap in fast mode");
    AST_NO_TICK: assert property (@(posedge i_mclk) disable iff (!rst_n_q)
        (!i_tick && !wr_cnt) |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved without a tick");
endmodule

// ==== rtl/tpwm_pkg.sv ====
// Shared constants, types and decode for the PWM timer block
package tpwm_pkg;
    localparam int          TP_W          = 8;
    localparam logic [7:0]  TP_BOTTOM     = 8'h00;
    localparam logic [7:0]  TP_MAX        = 8'hff;
    localparam logic [2:0]  TP_PC_8       = 3'h1;
    localparam logic [2:0]  TP_FAST_8     = 3'h3;
    localparam logic [2:0]  TP_PC_A       = 3'h5;
    localparam logic [2:0]  TP_FAST_A     = 3'h7;
    localparam logic [1:0]  TP_COM_OFF    = 2'h0;
    localparam logic [1:0]  TP_COM_TOG    = 2'h1;
    localparam int          TP_ADDR_W     = 5;
    localparam logic [4:0]  TP_OFF_CTRL   = 5'h00;
    localparam logic [4:0]  TP_OFF_CMPA   = 5'h04;
    localparam logic [4:0]  TP_OFF_CMPB   = 5'h08;
    localparam logic [4:0]  TP_OFF_COUNT  = 5'h0c;
    localparam logic [4:0]  TP_OFF_STAT   = 5'h10;
    localparam int          TP_CTRL_WGM2  = 2;
    localparam int          TP_CTRL_COMB  = 4;
    localparam int          TP_CTRL_COMA  = 6;
    localparam logic [7:0]  TP_CTRL_MASK  = 8'hf7;
    localparam logic [7:0]  TP_CTRL_RST   = 8'h00;
    localparam logic [7:0]  TP_CMP_RST    = 8'h00;
    localparam int          TP_STAT_OVF   = 0;
    localparam int          TP_STAT_UP    = 1;
    localparam logic [1:0]  TP_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  TP_RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {
        TPWM_UP   = 2'b01,
        TPWM_DOWN = 2'b10
    } tpwm_dir_t;

    function automatic logic tp_hit(input logic [TP_ADDR_W-1:0] a);
        return (a == TP_OFF_CTRL) || (a == TP_OFF_CMPA) ||
               (a == TP_OFF_CMPB) || (a == TP_OFF_COUNT) ||
               (a == TP_OFF_STAT);
    endfunction
endpackage

// ==== rtl/tpwm_axil.sv ====
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/10ps
module tpwm_axil
    import tpwm_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic [TP_ADDR_W-1:0] i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [TP_ADDR_W-1:0] i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic                      o_wr,
    output logic                      o_rd,
    input  wire logic [31:0]          i_rd_word
);
    logic bvalid_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    wire  wr_take = i_awvalid && i_wvalid && !bvalid_q;
    wire  rd_take = i_arvalid && !rvalid_q;

    // Address and data are taken together so no half-write is held
    assign o_awready = wr_take;
    assign o_wready  = wr_take;
    assign o_arready = !rvalid_q;
    assign o_wr      = wr_take && tp_hit(i_awaddr) && i_wstrb[0];
    assign o_rd      = rd_take;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_rvalid  = rvalid_q;
    assign o_rresp   = rresp_q;
    assign o_rdata   = rdata_q;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= TP_RESP_OKAY;
        end
        else if (wr_take)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= tp_hit(i_awaddr) ? TP_RESP_OKAY : TP_RESP_SLV;
        end
        else if (i_bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= TP_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= tp_hit(i_araddr) ? TP_RESP_OKAY : TP_RESP_SLV;
            rdata_q  <= tp_hit(i_araddr) ? i_rd_word : 32'h0000_0000;
        end
        else if (i_rready)
            rvalid_q <= 1'b0;
    end
endmodule

// ==== rtl/tpwm_chan.sv ====
// One compare output channel: waveform level and port override
`timescale 1ns/10ps
module tpwm_chan
    import tpwm_pkg::*;
#(
    parameter bit TOG_OK = 1'b1
)
(
    input  wire logic            i_mclk,
    input  wire logic            i_rst_n,
    input  wire logic            i_tick,
    input  wire logic            i_fast,
    input  wire logic            i_pc,
    input  wire logic            i_blk,
    input  wire logic            i_up,
    input  wire logic [TP_W-1:0] i_cnt,
    input  wire logic [TP_W-1:0] i_top,
    input  wire logic [TP_W-1:0] i_ocr,
    input  wire logic [1:0]      i_mode,
    input  wire logic            i_bit2,
    output logic                 o_out,
    output logic                 o_ovr
);
    logic out_q;
    logic seen_up_q;
    logic sym_q;
    logic ocr_top_q;
    wire pwm     = i_mode[1] && (i_fast || i_pc);
    wire tog     = TOG_OK && i_bit2 && (i_mode == TP_COM_TOG);
    wire match   = (i_cnt == i_ocr) && !i_blk;
    wire ocr_top = (i_ocr == i_top);
    wire at_top  = (i_cnt == i_top);
    wire at_bot  = (i_cnt == TP_BOTTOM);
    wire up_lvl  = i_mode[0];
    wire eff_up  = i_up || at_bot;
    wire leave   = i_pc && ocr_top_q && !ocr_top;
    wire missed  = i_pc && pwm && at_top && !seen_up_q && !ocr_top;
    logic out_d;

    always_comb
    begin
        out_d = out_q;
        if (i_tick && (i_fast || i_pc) && tog && match)
            out_d = !out_q;
        else if (i_tick && i_fast && pwm && at_top)
            out_d = !i_mode[0];
        else if (i_tick && i_fast && pwm && match && !ocr_top)
            out_d = i_mode[0];
        else if (i_tick && i_pc && pwm && ocr_top && at_top)
            out_d = !up_lvl;
        else if (i_tick && missed)
            out_d = up_lvl;
        else if (i_tick && i_pc && pwm && at_bot && sym_q)
            out_d = up_lvl;
        else if (i_tick && i_pc && pwm && match)
            out_d = eff_up ? up_lvl : !up_lvl;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            out_q     <= 1'b0;
            seen_up_q <= 1'b0;
            sym_q     <= 1'b0;
            ocr_top_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            if (i_tick)
            begin
                ocr_top_q <= ocr_top;
                seen_up_q <= (match && eff_up) || (seen_up_q && !at_bot);
                sym_q     <= leave || (sym_q && !at_bot);
            end
        end
    end

    // Mode zero leaves the pin to the port; toggle only where allowed
    assign o_ovr = i_mode[1] ||
                   (i_mode[0] && TOG_OK && (i_bit2 || !(i_fast || i_pc)));
    assign o_out = out_q;

    AST_OFF_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_mode == TP_COM_OFF) |=> (out_q == $past(out_q)))
        else $error("output moved with output mode off");
    AST_FAST_BOT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_tick && i_fast && i_mode[1] && at_top)
        |=> (out_q != $past(i_mode[0])))
        else $error("bottom level not applied at wrap");
    AST_PC_TOP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_tick && i_pc && i_mode[1] && ocr_top && at_top)
        |=> (out_q == !$past(up_lvl)))
        else $error("top compare level wrong in dual slope");
endmodule

// ==== testbench/test_tpwm_top.sv ====
// Self-checking bench for the PWM timer block with a reference model
`timescale 1ns/10ps
module test_tpwm_top;
    import tpwm_pkg::*;
    logic i_mclk = 0, i_reset_n = 0, i_tick = 0;
    logic [4:0] i_awaddr = 0, i_araddr = 0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic i_arvalid = 0, i_rready = 0;
    logic [31:0] i_wdata = 0, o_rdata, rd;
    logic [3:0] i_wstrb = 0;
    logic [1:0] o_bresp, o_rresp, rsp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_output_a, o_output_b, o_ovr_a, o_ovr_b, o_overflow_flag;
    logic [7:0] o_count_value, m_cnt, act_a, buf_a, act_b, ctl, top;
    logic m_oa = 0, m_ob = 0, ovf, m_up, blk, ha, hb, run = 0, on = 0;
    int failures = 0, tests_run = 0, cyc = 0;

    tpwm_top tpwm_top_inst (.*);

    initial forever #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) i_tick <= run ? 1'($urandom % 2) : 1'b0;
    always @(posedge i_mclk) if (++cyc == 8000) begin
        failures++;
        complete_run;
    end

    function automatic logic lvl(logic o, logic [1:0] cm, logic tg,
                                 logic m, logic bt, logic f, logic u);
        if (cm == 2'h1) return (tg && m) ? ~o : o;
        if (!cm[1]) return o;
        if (f && bt) return ~cm[0];
        if (m) return (f || u) ? cm[0] : ~cm[0];
        return o;
    endfunction

    // Model steps on the same sampled tick as the design
    always @(posedge i_mclk) if (i_tick)
    begin : mdl
        logic f, ma, mb, u, tp;
        logic [7:0] c;
        c = m_cnt;
        f = ctl[1:0] == 2'h3;
        top = ctl[2] ? act_a : 8'hff;
        ma = !blk && c == act_a;
        mb = !blk && c == act_b;
        u = m_up || c == 8'h00;
        tp = c == top;
        ha |= ma && u;
        hb |= mb && u;
        m_oa = lvl(m_oa, ctl[7:6], ctl[2], ma, tp, f, u);
        m_ob = lvl(m_ob, ctl[5:4], 1'b0, mb, tp, f, u);
        if (f)
        begin
            m_cnt = tp ? 8'h00 : c + 8'h01;
            ovf |= tp;
            if (tp) act_a = buf_a;
        end
        else if (m_up && tp)
        begin
            m_up = 0;
            m_cnt = c - 8'h01;
            act_a = buf_a;
            // Up match missed on the way up
            if (!ha && ctl[7]) m_oa = ctl[6];
            if (!hb && ctl[5]) m_ob = ctl[4];
            ha = 0;
            hb = 0;
        end
        else if (m_up) m_cnt = c + 8'h01;
        else if (c == 8'h00)
        begin
            m_up = 1;
            m_cnt = 8'h01;
            ovf = 1;
        end
        else m_cnt = c - 8'h01;
        blk = 0;
    end

    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    always @(negedge i_mclk) if (on)
    begin
        check("count", o_count_value, m_cnt);
        check("out_a", o_output_a, m_oa);
        check("out_b", o_output_b, m_ob);
        check("ovf", o_overflow_flag, ovf);
    end

    task automatic axw(logic [4:0] a, logic [31:0] d);
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        do @(posedge i_mclk); while (!(o_awready && o_wready));
        i_awvalid <= 0;
        i_wvalid <= 0;
        do @(posedge i_mclk); while (!o_bvalid);
        i_bready <= 0;
        rsp = o_bresp;
    endtask

    task automatic axr(logic [4:0] a);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        do @(posedge i_mclk); while (!o_arready);
        i_arvalid <= 0;
        do @(posedge i_mclk); while (!o_rvalid);
        i_rready <= 0;
        rd = o_rdata;
        rsp = o_rresp;
    endtask

    task automatic halt;
        run = 0;
        repeat (3) @(posedge i_mclk);
    endtask

    // Setup in normal mode so compares load at once
    task automatic cfg(logic [7:0] c, logic [7:0] ca, logic [7:0] cb, int n);
        halt;
        on = 0;
        axw(TP_OFF_CTRL, 0);
        axw(TP_OFF_COUNT, 0);
        axw(TP_OFF_CMPA, {24'h0, ca});
        axw(TP_OFF_CMPB, {24'h0, cb});
        axw(TP_OFF_STAT, 1);
        axr(TP_OFF_STAT);
        check("ovf_clr", rd[0], 1'b0);
        m_up = rd[1];
        {m_cnt, blk, act_a, buf_a, act_b, ovf, ha, hb} = {8'h0, 1'b1, ca, ca, cb, 3'h0};
        ctl = c;
        axw(TP_OFF_CTRL, {24'h0, c});
        check("ovr_a", o_ovr_a, c[7:6] != 2'h0);
        check("ovr_b", o_ovr_b, c[5:4] != 2'h0);
        on = 1;
        run = 1;
        repeat (n) @(posedge i_mclk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'heec9));
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1;
        repeat (3) @(posedge i_mclk);
        cfg(8'hb3, 8'h40, 8'h00, 700);
        halt;
        axw(TP_OFF_CMPA, 32'hff);
        buf_a = 8'hff;
        run = 1;
        repeat (700) @(posedge i_mclk);
        $display("fast pwm test done");
        cfg(8'h47, 8'h10, 8'h05, 300);
        $display("toggle test done");
        cfg(8'hb1, 8'h00, 8'h80, 2200);
        $display("dual slope test done");
        // Mode 5: ceiling from compare_a, channel B non-inverting
        cfg(8'h25, 8'h30, 8'h10, 600);
        $display("dual slope compare ceiling test done");
        halt;
        on = 0;
        axw(5'h14, 32'h1);
        check("bresp", rsp, TP_RESP_SLV);
        axr(5'h14);
        check("rresp", rsp, TP_RESP_SLV);
        check("rdata", rd, 32'h0);
        axw(TP_OFF_CTRL, 32'hff);
        axr(TP_OFF_CTRL);
        check("ctrl", rd, 32'hf7);
        axw(TP_OFF_CTRL, 0);
        $display("register test done");
        complete_run;
    end
endmodule
